// ---- rtl/flash_protect_pkg.sv ----
// constants for the flash protection and boot configuration block
package flash_protect_pkg;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] boot_config_addr  = 8'h00;
  localparam logic [7:0] status_addr       = 8'h04;
  localparam logic [7:0] command_addr      = 8'h08;
  localparam logic [7:0] cmd_result_addr   = 8'h0c;
  localparam logic [7:0] array_addr_addr   = 8'h10;

  // ==========================================================================
  // boot configuration fields
  // ==========================================================================
  localparam int boot_addr_lsb  = 5;
  localparam int boot_addr_msb  = 23;
  localparam int boot_delay_lsb = 1;
  localparam int boot_delay_msb = 4;
  localparam int boot_enable_pos = 0;
  localparam logic [31:0] boot_config_reset = 32'h0000_0000;
  localparam logic [31:0] boot_config_mask  = 32'h00ff_ffff;
  localparam logic [3:0] fast_read_dummy  = 4'h8;
  localparam logic [3:0] quad_io_dummy    = 4'h6;

  // ==========================================================================
  // status register fields
  // ==========================================================================
  localparam int wip_pos        = 0;
  localparam int wel_pos        = 1;
  localparam int bp_lsb         = 2;
  localparam int bp_msb         = 5;
  localparam int quad_en_pos    = 6;
  localparam int status_lock_pos = 7;
  localparam logic [7:0] status_reset     = 8'h00;
  localparam logic [7:0] status_protected_mask = 8'hfc;

  // ==========================================================================
  // commands
  // ==========================================================================
  localparam logic [7:0] write_enable_cmd  = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] write_status_cmd  = 8'h01;
  localparam logic [7:0] program_cmd       = 8'h02;
  localparam logic [7:0] erase_cmd         = 8'h20;
  localparam logic [7:0] chip_erase_cmd    = 8'hc7;
  localparam logic [7:0] boot_write_cmd    = 8'h65;

  // result codes
  localparam logic [1:0] res_done      = 2'h1;
  localparam logic [1:0] res_no_wel    = 2'h2;
  localparam logic [1:0] res_protected = 2'h3;

  localparam int array_addr_w = 22;

endpackage : flash_protect_pkg

// ---- rtl/region_decode.sv ----
// block protect decoder: is an array address inside the protected region
`timescale 1ns/100ps
module region_decode (
  input  wire logic [3:0]  bp_i,
  input  wire logic [21:0] addr_i,
  output logic             hit_o
);
  // ==========================================================================
  // top-down protection, each step up to 7 doubles the protected size; 8 and up protect the whole array
  // ==========================================================================
  logic [4:0]  shift_w;
  logic [21:0] limit_w;
  assign shift_w = (bp_i >= 4'h8) ? 5'h16 : {1'b0, bp_i} + 5'h0d;
  assign limit_w = (bp_i >= 4'h8) ? 22'h0 :
                   22'h3fffff - ((22'h1 << shift_w) - 22'h1);
  assign hit_o = (bp_i != 4'h0) && (addr_i >= limit_w);
endmodule : region_decode

// ---- rtl/flash_protect_autoboot_cfg.sv ----
// write protection and boot configuration for a serial flash device
// Notes on behaviour
// RULE1 - boot start address sits in config bits 23:5, 32-byte aligned, resets zero
// RULE2 - boot delay bits 4:1; zero gives 8 or 6 cycles by quad enable
// RULE3 - boot output enabled only when config bit 0 is one
// RULE4 - status protected only when lock bit set and lock pin low
// RULE5 - pin protection covers block protect, lock and quad enable bits
// RULE6 - program, erase and register writes need the write enable latch set
// RULE7 - block protect bits guard part or all of the array
// RULE8 - protected status write is discarded quietly; later commands still work
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module flash_protect_autoboot_cfg (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_lock_n_i,
  output logic             boot_enable_o,
  output logic [23:0]      boot_start_address_o,
  output logic [3:0]       boot_delay_cycles_o,
  output logic             array_write_o,
  output logic             array_erase_o,
  output logic [21:0]      array_addr_o
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [31:0] boot_config_reg_q;
  logic [7:0]  status_q;
  logic [1:0]  result_q;
  logic [21:0] array_addr_q;
  logic        array_write_q;
  logic        array_erase_q;

  // ==========================================================================
  // bus decode
  // ==========================================================================
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  logic wr_w;
  logic rd_hit_w;
  logic wr_cfg_w;
  logic wr_cmd_w;
  logic wr_addr_w;
  assign wr_w = psel && penable && pwrite;
  assign wr_cfg_w  = wr_w && hit(paddr, flash_protect_pkg::boot_config_addr);
  assign wr_cmd_w  = wr_w && hit(paddr, flash_protect_pkg::command_addr);
  assign wr_addr_w = wr_w && hit(paddr, flash_protect_pkg::array_addr_addr);
  assign rd_hit_w = hit(paddr, flash_protect_pkg::boot_config_addr) ||
                    hit(paddr, flash_protect_pkg::status_addr) ||
                    hit(paddr, flash_protect_pkg::command_addr) ||
                    hit(paddr, flash_protect_pkg::cmd_result_addr) ||
                    hit(paddr, flash_protect_pkg::array_addr_addr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit_w;

  // ==========================================================================
  // protection decisions
  // ==========================================================================
  logic       wel_w;
  logic       sr_locked_w;
  logic [3:0] bp_w;
  logic       region_hit_w;
  logic [7:0] cmd_w;
  logic       is_write_w;
  logic       is_array_w;
  logic [7:0] status_new_w;
  assign wel_w = status_q[flash_protect_pkg::wel_pos];
  assign bp_w  = status_q[flash_protect_pkg::bp_msb:flash_protect_pkg::bp_lsb];
  assign sr_locked_w = status_q[flash_protect_pkg::status_lock_pos] &&
                       !hw_lock_n_i; // RULE4
  assign cmd_w = pwdata[7:0];
  assign is_array_w = (cmd_w == flash_protect_pkg::program_cmd) ||
                      (cmd_w == flash_protect_pkg::erase_cmd) ||
                      (cmd_w == flash_protect_pkg::chip_erase_cmd);
  assign is_write_w = is_array_w ||
                      (cmd_w == flash_protect_pkg::write_status_cmd) ||
                      (cmd_w == flash_protect_pkg::boot_write_cmd);

  region_decode u_region (
    .bp_i   (bp_w),
    .addr_i (array_addr_q),
    .hit_o  (region_hit_w)
  );

  logic chip_blocked_w;
  assign chip_blocked_w = (cmd_w == flash_protect_pkg::chip_erase_cmd) &&
                          (bp_w != 4'h0); // RULE7
  // a locked write keeps bits 7:2; either way the latch clears after it
  assign status_new_w = flash_protect_pkg::status_protected_mask &
    (sr_locked_w ? status_q : pwdata[15:8]); // RULE5 RULE8

  // every program, erase and register write is gated by the latch
  logic accept_w;
  assign accept_w = wr_cmd_w && is_write_w && wel_w; // RULE6

  // chip erase is refused as soon as any block is protected
  logic protect_hit_w;
  assign protect_hit_w = is_array_w && (region_hit_w || chip_blocked_w);

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_config_reg_q <= flash_protect_pkg::boot_config_reset; // RULE1
    end else if (wr_cfg_w && wel_w) begin
      boot_config_reg_q <= pwdata & flash_protect_pkg::boot_config_mask;
    end else if (accept_w && cmd_w == flash_protect_pkg::boot_write_cmd) begin
      boot_config_reg_q <= {8'h00, pwdata[31:8]} &
                           flash_protect_pkg::boot_config_mask;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      array_addr_q <= 22'h0;
    end else if (wr_addr_w) begin
      array_addr_q <= pwdata[21:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= flash_protect_pkg::status_reset;
    end else if (wr_cmd_w && cmd_w == flash_protect_pkg::write_enable_cmd) begin
      status_q[flash_protect_pkg::wel_pos] <= 1'b1;
    end else if (wr_cmd_w && cmd_w == flash_protect_pkg::write_disable_cmd) begin
      status_q[flash_protect_pkg::wel_pos] <= 1'b0;
    end else if (accept_w &&
                 cmd_w == flash_protect_pkg::write_status_cmd) begin
      status_q <= status_new_w;
    end else if (accept_w) begin
      status_q[flash_protect_pkg::wel_pos] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result_q      <= 2'h0;
      array_write_q <= 1'b0;
      array_erase_q <= 1'b0;
    end else begin
      array_write_q <= accept_w && !protect_hit_w &&
                       cmd_w == flash_protect_pkg::program_cmd; // RULE7
      array_erase_q <= accept_w && !protect_hit_w &&
                       cmd_w != flash_protect_pkg::program_cmd &&
                       is_array_w; // RULE7
      if (wr_cmd_w && is_write_w) begin
        if (!wel_w) begin
          result_q <= flash_protect_pkg::res_no_wel; // RULE6
        end else if (protect_hit_w ||
                     (cmd_w == flash_protect_pkg::write_status_cmd &&
                      sr_locked_w)) begin
          result_q <= flash_protect_pkg::res_protected; // RULE8
        end else begin
          result_q <= flash_protect_pkg::res_done;
        end
      end
    end
  end

  // ==========================================================================
  // boot outputs
  // ==========================================================================
  logic [3:0] delay_field_w;
  assign delay_field_w = boot_config_reg_q[flash_protect_pkg::boot_delay_msb:
                                           flash_protect_pkg::boot_delay_lsb];
  assign boot_enable_o =
    boot_config_reg_q[flash_protect_pkg::boot_enable_pos]; // RULE3
  assign boot_start_address_o =
    {boot_config_reg_q[flash_protect_pkg::boot_addr_msb:
                       flash_protect_pkg::boot_addr_lsb], 5'h00}; // RULE1
  assign boot_delay_cycles_o =
    (delay_field_w != 4'h0) ? delay_field_w :
    (status_q[flash_protect_pkg::quad_en_pos] ?
     flash_protect_pkg::quad_io_dummy :
     flash_protect_pkg::fast_read_dummy); // RULE2
  assign array_write_o = array_write_q;
  assign array_erase_o = array_erase_q;
  assign array_addr_o  = array_addr_q;

  // ==========================================================================
  // read mux
  // ==========================================================================
  // read data is captured in the setup cycle so that prdata comes from a
  // flop; a write always completes at least one edge before the next setup
  logic [31:0] rdata_w;
  logic [31:0] prdata_q;
  logic        setup_w;
  assign setup_w = psel && !penable;

  always_comb begin
    rdata_w = 32'h0000_0000;
    if (hit(paddr, flash_protect_pkg::boot_config_addr)) begin
      rdata_w = boot_config_reg_q;
    end else if (hit(paddr, flash_protect_pkg::status_addr)) begin
      rdata_w = {24'h0, status_q};
    end else if (hit(paddr, flash_protect_pkg::cmd_result_addr)) begin
      rdata_w = {30'h0, result_q};
    end else if (hit(paddr, flash_protect_pkg::array_addr_addr)) begin
      rdata_w = {10'h0, array_addr_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_q <= rdata_w;
    end
  end
  assign prdata = prdata_q;

endmodule : flash_protect_autoboot_cfg

// ---- sim/flash_protect_autoboot_cfg_asserts.sv ----
// port-level assertions for the flash protection and boot configuration block
`timescale 1ns/100ps
module flash_protect_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        boot_enable_o,
  input wire logic [23:0] boot_start_address_o,
  input wire logic [3:0]  boot_delay_cycles_o,
  input wire logic        array_write_o,
  input wire logic        array_erase_o,
  input wire logic [21:0] array_addr_o
);
  // ==========================================================================
  // access decode
  // ==========================================================================
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic       acc_w = psel && penable && pwrite;
  wire logic       cmd_w = acc_w && paddr == flash_protect_pkg::command_addr;
  wire logic [7:0] op    = pwdata[7:0];

  chk_addr_align: assert property (boot_start_address_o[4:0] == 5'h00)
    else $error("boot start address not aligned");
  chk_reset_cfg: assert property ($rose(rst_n_i) |-> !boot_enable_o
    && boot_delay_cycles_o == 4'h8 && boot_start_address_o == 24'h000000)
    else $error("boot outputs wrong after reset");
  chk_delay_nonzero: assert property (boot_delay_cycles_o != 4'h0)
    else $error("boot delay of zero cycles");
  chk_cfg_hold: assert property (!$past(acc_w && (paddr == 8'h00
    || paddr == 8'h08)) |-> $stable(boot_enable_o)
    && $stable(boot_start_address_o) && $stable(boot_delay_cycles_o))
    else $error("boot outputs moved without a write");
  chk_prog_cause: assert property ($rose(array_write_o) |->
    $past(cmd_w && op == flash_protect_pkg::program_cmd))
    else $error("array write without program command");
  chk_erase_cause: assert property ($rose(array_erase_o) |->
    $past(cmd_w && (op == 8'h20 || op == 8'hc7)))
    else $error("array erase without erase command");
  chk_pulse_once: assert property (array_write_o || array_erase_o |=>
    !array_write_o && !array_erase_o)
    else $error("array pulse longer than one cycle");
  chk_addr_hold: assert property (!$past(acc_w && paddr == 8'h10) |->
    $stable(array_addr_o))
    else $error("array address moved without a write");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h10 |->
    pslverr)
    else $error("no error on unmapped access");
endmodule : flash_protect_chk

bind flash_protect_autoboot_cfg flash_protect_chk i_flash_protect_chk (
  .clk_i, .rst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .boot_enable_o, .boot_start_address_o, .boot_delay_cycles_o,
  .array_write_o, .array_erase_o, .array_addr_o);

// ---- sim/apb_host_model.sv ----
// apb master standing in for the host controller
`timescale 1ns/100ps
module apb_host_model (
  input  wire logic        clk_i,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // released address and data lines show the inverse of the last value
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host_model

// ---- sim/tb_flash_protect_autoboot_cfg.sv ----
// register-level testbench for the flash protection and boot configuration
`timescale 1ns/100ps
module tb_flash_protect_autoboot_cfg;
  logic        clk_i, rst_n_i, hw_lock_n_i, psel, penable, pwrite;
  logic        pready, pslverr, err_v, boot_enable_o, array_write_o;
  logic        array_erase_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [23:0] boot_start_address_o;
  logic [3:0]  boot_delay_cycles_o;
  logic [21:0] array_addr_o;
  int          n_fail = 0, checks_done = 0, n_wr = 0, n_er = 0;

  flash_protect_autoboot_cfg i_flash_protect_autoboot_cfg (.clk_i, .rst_n_i,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hw_lock_n_i, .boot_enable_o, .boot_start_address_o,
    .boot_delay_cycles_o, .array_write_o, .array_erase_o, .array_addr_o);
  apb_host_model i_apb_host_model (.clk_i, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (array_write_o === 1'b1) n_wr++;
    if (array_erase_o === 1'b1) n_er++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_apb_host_model.xfer(1'b1, a, d, rd_v, err_v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_apb_host_model.xfer(1'b0, a, 32'h0, rd_v, err_v);
    check(rd_v, exp, "read data");
  endtask : rd
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat = 8'h00);
    wr(8'h08, {16'h0000, dat, op});
  endtask : cmd
  task automatic res(input logic [1:0] exp);
    i_apb_host_model.xfer(1'b0, 8'h0c, 32'h0, rd_v, err_v);
    check({30'h0, rd_v[1:0]}, {30'h0, exp}, "result");
  endtask : res
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  initial begin
    #200us;
    n_fail++;
    test_done();
  end

  initial begin
    rst_n_i = 1'b0;
    hw_lock_n_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 32'h0);
    check({31'h0, boot_enable_o}, 32'h0, "boot enable");
    check({28'h0, boot_delay_cycles_o}, 32'h8, "delay");
    wr(8'h00, 32'h0012_345b);
    rd(8'h00, 32'h0);
    cmd(8'h06);
    wr(8'h00, 32'h0012_345b);
    rd(8'h00, 32'h0012_345b);
    check({8'h0, boot_start_address_o}, 32'h123440, "start");
    check({28'h0, boot_delay_cycles_o}, 32'hd, "delay");
    check({31'h0, boot_enable_o}, 32'h1, "boot enable");
    cmd(8'h65, 8'h20);
    rd(8'h00, 32'h20);
    check({31'h0, boot_enable_o}, 32'h0, "boot enable");
    cmd(8'h06);
    cmd(8'h01, 8'h40);
    rd(8'h04, 32'h40);
    check({28'h0, boot_delay_cycles_o}, 32'h6, "delay");
    hw_lock_n_i <= 1'b0;
    cmd(8'h06);
    cmd(8'h01, 8'hc0);
    rd(8'h04, 32'hc0);
    cmd(8'h06);
    cmd(8'h01, 8'h3c);
    rd(8'h04, 32'hc0);
    res(flash_protect_pkg::res_protected);
    cmd(8'h06);
    rd(8'h04, 32'hc2);
    hw_lock_n_i <= 1'b1;
    cmd(8'h01, 8'h00);
    rd(8'h04, 32'h00);
    wr(8'h10, 32'h100);
    cmd(8'h02);
    res(flash_protect_pkg::res_no_wel);
    cmd(8'h06);
    cmd(8'h02);
    res(flash_protect_pkg::res_done);
    check(32'(n_wr), 32'h1, "writes");
    check({10'h0, array_addr_o}, 32'h100, "array address");
    cmd(8'h06);
    cmd(8'h01, 8'h3c);
    cmd(8'h06);
    cmd(8'h02);
    res(flash_protect_pkg::res_protected);
    cmd(8'h06);
    cmd(8'hc7);
    res(flash_protect_pkg::res_protected);
    check(32'(n_wr + n_er), 32'h1, "array pulses");
    cmd(8'h06);
    cmd(8'h01, 8'h00);
    cmd(8'h06);
    cmd(8'h20);
    res(flash_protect_pkg::res_done);
    check(32'(n_er), 32'h1, "erases");
    cmd(8'h06);
    cmd(8'h01, 8'h04);
    rd(8'h04, 32'h04);
    wr(8'h10, 32'h003f_ff00);
    cmd(8'h06);
    cmd(8'h02);
    res(flash_protect_pkg::res_protected);
    wr(8'h10, 32'h003f_bf00);
    cmd(8'h06);
    cmd(8'h02);
    res(flash_protect_pkg::res_done);
    check(32'(n_wr), 32'h2, "writes");
    i_apb_host_model.xfer(1'b0, 8'h14, 32'h0, rd_v, err_v);
    check({31'h0, err_v}, 32'h1, "slave error");
    test_done();
  end
endmodule : tb_flash_protect_autoboot_cfg
